// file: shared/utrx_defs.vh
// Register map, field positions and reset values of the serial transceiver.
`ifndef UTRX_DEFS_VH
`define UTRX_DEFS_VH

`define UTRX_ADDR_STATUS   3'h0
`define UTRX_ADDR_CTRL1    3'h1
`define UTRX_ADDR_CTRL2    3'h2
`define UTRX_ADDR_BAUD     3'h3
`define UTRX_ADDR_DATA     3'h4

// Status register bits.
`define UTRX_ST_PARITY     0
`define UTRX_ST_NOISE      1
`define UTRX_ST_FRAMING    2
`define UTRX_ST_OVERRUN    3
`define UTRX_ST_RX_IDLE    4
`define UTRX_ST_RX_AVAIL   5
`define UTRX_ST_TX_IDLE    6
`define UTRX_ST_TX_EMPTY   7

// Control register 1 bits.
`define UTRX_C1_WORD9      0
`define UTRX_C1_PAR_EN     1
`define UTRX_C1_PAR_ODD    2
`define UTRX_C1_STOP2      3
`define UTRX_C1_BREAK      4
`define UTRX_C1_TX_NINTH   5
`define UTRX_C1_RX_NINTH   6

// Control register 2 bits.
`define UTRX_C2_TX_EN      0
`define UTRX_C2_RX_EN      1
`define UTRX_C2_BAUD_HS    2
`define UTRX_C2_TXE_IE     3
`define UTRX_C2_RX_IE      4

`define UTRX_CTRL1_RST     6'h00
`define UTRX_CTRL2_RST     5'h00
`define UTRX_BAUD_RST      8'h00

// Oversampling and frame timing, in oversample ticks and bits; UTRX_LS_PRE is the low-speed prescale, in clocks.
`define UTRX_OVS_LAST      4'hF
`define UTRX_OVS_S1        4'h7
`define UTRX_OVS_S2        4'h8
`define UTRX_OVS_VOTE      4'h9
`define UTRX_BRK_BITS      4'hD
`define UTRX_LS_PRE        2'h3

`endif

// file: hw/utrx_core.v
// Serial transceiver datapath: transmitter, 16x oversampled receiver and register port.
`include "utrx_defs.vh"

module utrx_core
(
    input  wire       clk_in,     // 125 MHz clock
    input  wire       reset_in,   // synchronous reset, active high
    input  wire [2:0] addr_in,    // register address
    input  wire [7:0] wdata_in,   // write data
    input  wire       wr_in,      // write strobe
    input  wire       rd_in,      // read strobe
    output reg  [7:0] rdata_out,  // read data, cycle after read strobe
    input  wire       rx_pin_in,  // serial receive line
    output reg        tx_pin_out, // serial transmit line
    output reg        irq_out     // interrupt request, active high
);
    localparam T_IDLE  = 3'h0;
    localparam T_START = 3'h1;
    localparam T_DATA  = 3'h2;
    localparam T_STOP  = 3'h3;
    localparam T_BREAK = 3'h4;
    localparam R_IDLE  = 2'h0;
    localparam R_START = 2'h1;
    localparam R_DATA  = 2'h2;
    localparam R_STOP  = 2'h3;

    // Parity bit for a word of 8 or 9 bits whose top bit is the parity slot.
    function par_bit;
        input [8:0] w;
        input       nine;
        input       odd;
        begin
            par_bit = (nine ? ^w[7:0] : ^w[6:0]) ^ odd;
        end
    endfunction

    function maj3;
        input a;
        input b;
        input c;
        begin
            maj3 = (a & b) | (a & c) | (b & c);
        end
    endfunction

    reg [5:0] ctrl1_r;
    reg [4:0] ctrl2_r;
    reg [7:0] baud_div_r;
    reg       status_seen_r;
    wire      word_length_sel     = ctrl1_r[`UTRX_C1_WORD9];
    wire      parity_enable       = ctrl1_r[`UTRX_C1_PAR_EN];
    wire      parity_type_sel     = ctrl1_r[`UTRX_C1_PAR_ODD];
    wire      stop_bits_sel       = ctrl1_r[`UTRX_C1_STOP2];
    wire      send_break          = ctrl1_r[`UTRX_C1_BREAK];
    wire      tx_ninth_bit        = ctrl1_r[`UTRX_C1_TX_NINTH];
    wire      transmitter_enable  = ctrl2_r[`UTRX_C2_TX_EN];
    wire      receiver_enable     = ctrl2_r[`UTRX_C2_RX_EN];
    wire      baud_high_speed_sel = ctrl2_r[`UTRX_C2_BAUD_HS];
    wire      tx_empty_irq_enable = ctrl2_r[`UTRX_C2_TXE_IE];
    wire      rx_irq_enable       = ctrl2_r[`UTRX_C2_RX_IE];
    wire      wr_data = wr_in && (addr_in == `UTRX_ADDR_DATA);
    wire      rd_data = rd_in && (addr_in == `UTRX_ADDR_DATA);

    // Baud generator: one tick per oversample period.
    reg [9:0] bcnt_r;
    reg       tick_r;
    wire [9:0] blimit = baud_high_speed_sel ? {2'h0, baud_div_r} : {baud_div_r, `UTRX_LS_PRE};
    always @(posedge clk_in)
    begin
        if (reset_in || bcnt_r == blimit)
            bcnt_r <= 10'h000;
        else
            bcnt_r <= bcnt_r + 10'h001;
        tick_r <= !reset_in && (bcnt_r == blimit);
    end

    // Break arming: send_break must stay high longer than divisor+1 cycles.
    reg [8:0] brk_cnt_r;
    reg       brk_armed_r;
    always @(posedge clk_in)
    begin
        if (reset_in || !send_break)
        begin
            brk_cnt_r   <= 9'h000;
            brk_armed_r <= 1'b0;
        end
        else if (brk_cnt_r > {1'b0, baud_div_r})
            brk_armed_r <= 1'b1;
        else
            brk_cnt_r <= brk_cnt_r + 9'h001;
    end

    // Transmitter.
    reg [2:0] tx_st_r;
    reg [8:0] tx_sh_r;
    reg [8:0] tx_buf_r;
    reg       tx_buf_full_r;
    reg [3:0] tx_ph_r;
    reg [3:0] tx_bit_r;
    reg       tx_empty_r;
    reg       tx_idle_r;
    reg [8:0] tx_word;
    always @*
    begin
        tx_word = {tx_ninth_bit, wdata_in};
        if (!word_length_sel)
            tx_word[8] = 1'b0;
        if (parity_enable && word_length_sel)
            tx_word[8] = par_bit(tx_word, 1'b1, parity_type_sel);
        else if (parity_enable)
            tx_word[7] = par_bit(tx_word, 1'b0, parity_type_sel);
    end
    wire tx_bit_end = tick_r && (tx_ph_r == `UTRX_OVS_LAST);
    wire tx_accept  = wr_data && tx_empty_r;
    wire [3:0] tx_nbits = word_length_sel ? 4'h8 : 4'h7;

    always @(posedge clk_in)
    begin
        if (reset_in || !transmitter_enable)
        begin
            tx_st_r       <= T_IDLE;
            tx_sh_r       <= 9'h000;
            tx_buf_r      <= 9'h000;
            tx_buf_full_r <= 1'b0;
            tx_ph_r       <= 4'h0;
            tx_bit_r      <= 4'h0;
            tx_empty_r    <= 1'b1;
            tx_idle_r     <= 1'b1;
            tx_pin_out    <= 1'b1;
        end
        else
        begin
            if (tx_accept && status_seen_r)
                tx_idle_r <= 1'b0;
            if (tx_st_r != T_IDLE && tick_r)
                tx_ph_r <= tx_ph_r + 4'h1;
            case (tx_st_r)
                T_IDLE:
                begin
                    tx_pin_out <= 1'b1;
                    tx_ph_r    <= 4'h0;
                    tx_bit_r   <= 4'h0;
                    if (tx_accept)
                    begin
                        tx_sh_r   <= tx_word;
                        tx_st_r   <= T_START;
                        tx_idle_r <= 1'b0;
                    end
                    else if (tx_buf_full_r)
                    begin
                        // A write that landed in the last stop cycle is still parked here.
                        tx_sh_r       <= tx_buf_r;
                        tx_buf_full_r <= 1'b0;
                        tx_empty_r    <= 1'b1;
                        tx_st_r       <= T_START;
                    end
                    else if (brk_armed_r)
                        tx_st_r <= T_BREAK;
                end
                T_START:
                begin
                    tx_pin_out <= 1'b0;
                    if (tx_bit_end)
                        tx_st_r <= T_DATA;
                end
                T_DATA:
                begin
                    tx_pin_out <= tx_sh_r[0];
                    if (tx_bit_end)
                    begin
                        tx_sh_r <= {1'b0, tx_sh_r[8:1]};
                        if (tx_bit_r == tx_nbits)
                        begin
                            tx_bit_r <= 4'h0;
                            tx_st_r  <= T_STOP;
                        end
                        else
                            tx_bit_r <= tx_bit_r + 4'h1;
                    end
                end
                T_BREAK:
                begin
                    // Slot 0 is the start bit; slots 1 to 13 hold the zero run, which repeats from slot 1.
                    tx_pin_out <= 1'b0;
                    if (tx_bit_end)
                    begin
                        if (tx_bit_r == `UTRX_BRK_BITS)
                        begin
                            if (send_break)
                                tx_bit_r <= 4'h1;
                            else
                            begin
                                tx_bit_r <= 4'h0;
                                tx_st_r  <= T_STOP;
                            end
                        end
                        else
                            tx_bit_r <= tx_bit_r + 4'h1;
                    end
                end
                T_STOP:
                begin
                    tx_pin_out <= 1'b1;
                    if (tx_bit_end)
                    begin
                        if (tx_bit_r == {3'h0, stop_bits_sel})
                        begin
                            tx_bit_r  <= 4'h0;
                            tx_idle_r <= 1'b1;
                            if (tx_buf_full_r)
                            begin
                                tx_sh_r       <= tx_buf_r;
                                tx_buf_full_r <= 1'b0;
                                tx_empty_r    <= 1'b1;
                                tx_st_r       <= T_START;
                            end
                            else
                                tx_st_r <= T_IDLE;
                        end
                        else
                            tx_bit_r <= tx_bit_r + 4'h1;
                    end
                end
                default:
                    tx_st_r <= T_IDLE;
            endcase
            // A write while a frame is under way is parked in the buffer.
            if (tx_accept && tx_st_r != T_IDLE)
            begin
                tx_buf_r      <= tx_word;
                tx_buf_full_r <= 1'b1;
                tx_empty_r    <= 1'b0;
            end
        end
    end

    // Receiver: two-flop synchroniser, then three samples per bit.
    reg       rx_s1_r;
    reg       rx_s2_r;
    reg [1:0] rx_samp_r;
    reg [1:0] rx_st_r;
    reg [3:0] rx_ph_r;
    reg [3:0] rx_bit_r;
    reg [8:0] rx_sh_r;
    reg       rx_noise_acc_r;
    reg       rx_wait_high_r;
    reg       rx_idle_r;
    reg       rx_ev_r;
    reg [8:0] fifo_mem [0:1];
    reg       fifo_wp_r;
    reg       fifo_rp_r;
    reg [1:0] fifo_cnt_r;
    reg       parity_flag_r;
    reg       noise_flag_r;
    reg       framing_flag_r;
    reg       overrun_flag_r;
    wire      vote     = maj3(rx_samp_r[1], rx_samp_r[0], rx_s2_r);
    wire      noisy    = (rx_samp_r[1] != rx_samp_r[0]) || (rx_samp_r[0] != rx_s2_r);
    wire      at_vote  = tick_r && (rx_ph_r == `UTRX_OVS_VOTE);
    wire      ph_end   = tick_r && (rx_ph_r == `UTRX_OVS_LAST);
    wire [8:0] rx_word = word_length_sel ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
    wire      rx_pop   = rd_data && (fifo_cnt_r != 2'h0);
    wire      err_clr  = rd_data && status_seen_r;
    wire      rx_done  = (rx_st_r == R_STOP) && at_vote;
    wire      rx_push  = rx_done && (fifo_cnt_r != 2'h2 || rx_pop);
    wire      rx_ovr   = rx_done && !rx_push;
    wire      rx_perr  = parity_enable && (par_bit(rx_word, word_length_sel, parity_type_sel)
                         != (word_length_sel ? rx_word[8] : rx_word[7]));

    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end
        else
        begin
            rx_s1_r <= rx_pin_in;
            rx_s2_r <= rx_s1_r;
        end
    end

    always @(posedge clk_in)
    begin
        if (reset_in || !receiver_enable)
        begin
            rx_samp_r      <= 2'h3;
            rx_st_r        <= R_IDLE;
            rx_ph_r        <= 4'h0;
            rx_bit_r       <= 4'h0;
            rx_sh_r        <= 9'h000;
            rx_noise_acc_r <= 1'b0;
            rx_wait_high_r <= 1'b1;
            rx_idle_r      <= 1'b1;
        end
        else
        begin
            if (tick_r && (rx_ph_r == `UTRX_OVS_S1 || rx_ph_r == `UTRX_OVS_S2))
                rx_samp_r <= {rx_samp_r[0], rx_s2_r};
            if (tick_r)
                rx_ph_r <= rx_ph_r + 4'h1;
            case (rx_st_r)
                R_IDLE:
                begin
                    rx_ph_r <= 4'h0;
                    if (rx_s2_r)
                        rx_wait_high_r <= 1'b0;
                    else if (!rx_wait_high_r)
                    begin
                        rx_st_r        <= R_START;
                        rx_idle_r      <= 1'b0;
                        rx_noise_acc_r <= 1'b0;
                        rx_bit_r       <= 4'h0;
                    end
                end
                R_START:
                begin
                    if (at_vote && vote)
                    begin
                        rx_st_r   <= R_IDLE;
                        rx_idle_r <= 1'b1;
                    end
                    else if (ph_end)
                        rx_st_r <= R_DATA;
                end
                R_DATA:
                begin
                    if (at_vote)
                    begin
                        rx_sh_r        <= {vote, rx_sh_r[8:1]};
                        rx_noise_acc_r <= rx_noise_acc_r | noisy;
                    end
                    if (ph_end)
                    begin
                        if (rx_bit_r == tx_nbits)
                            rx_st_r <= R_STOP;
                        else
                            rx_bit_r <= rx_bit_r + 4'h1;
                    end
                end
                R_STOP:
                begin
                    // Only one stop bit is checked; the frame closes at its vote.
                    if (at_vote)
                    begin
                        rx_st_r        <= R_IDLE;
                        rx_idle_r      <= 1'b1;
                        rx_wait_high_r <= !vote;
                    end
                end
                default:
                    rx_st_r <= R_IDLE;
            endcase
        end
    end

    // Receive buffer and error flags; a new event wins over a clearing read.
    always @(posedge clk_in)
    begin
        if (reset_in || !receiver_enable)
        begin
            fifo_wp_r      <= 1'b0;
            fifo_rp_r      <= 1'b0;
            fifo_cnt_r     <= 2'h0;
            parity_flag_r  <= 1'b0;
            noise_flag_r   <= 1'b0;
            framing_flag_r <= 1'b0;
            overrun_flag_r <= 1'b0;
            rx_ev_r        <= 1'b0;
        end
        else
        begin
            if (rx_push)
            begin
                fifo_mem[fifo_wp_r] <= rx_word;
                fifo_wp_r <= ~fifo_wp_r;
            end
            if (rx_pop)
                fifo_rp_r <= ~fifo_rp_r;
            fifo_cnt_r <= fifo_cnt_r + {1'b0, rx_push} - {1'b0, rx_pop};
            if (rx_done)
            begin
                framing_flag_r <= !vote || (framing_flag_r && !err_clr);
                noise_flag_r   <= rx_noise_acc_r || noisy || (noise_flag_r && !err_clr);
                parity_flag_r  <= rx_perr || (parity_flag_r && !err_clr);
            end
            else if (err_clr)
            begin
                framing_flag_r <= 1'b0;
                noise_flag_r   <= 1'b0;
                parity_flag_r  <= 1'b0;
            end
            if (rx_ovr)
                overrun_flag_r <= 1'b1;
            else if (err_clr)
                overrun_flag_r <= 1'b0;
            rx_ev_r <= rx_done;
        end
    end

    // Register port.
    wire [7:0] status = {tx_empty_r, tx_idle_r, (fifo_cnt_r != 2'h0), rx_idle_r,
                         overrun_flag_r, framing_flag_r, noise_flag_r, parity_flag_r};
    wire [8:0] rx_head = fifo_mem[fifo_rp_r];
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            ctrl1_r       <= `UTRX_CTRL1_RST;
            ctrl2_r       <= `UTRX_CTRL2_RST;
            baud_div_r    <= `UTRX_BAUD_RST;
            status_seen_r <= 1'b0;
            rdata_out     <= 8'h00;
            irq_out       <= 1'b0;
        end
        else
        begin
            if (wr_in && addr_in == `UTRX_ADDR_CTRL1)
                ctrl1_r <= wdata_in[5:0];
            if (wr_in && addr_in == `UTRX_ADDR_CTRL2)
                ctrl2_r <= wdata_in[4:0];
            if (wr_in && addr_in == `UTRX_ADDR_BAUD)
                baud_div_r <= wdata_in;
            if (rd_in && addr_in == `UTRX_ADDR_STATUS)
                status_seen_r <= 1'b1;
            else if (rd_data || wr_data)
                status_seen_r <= 1'b0;
            rdata_out <= 8'h00;
            if (rd_in)
            begin
                case (addr_in)
                    `UTRX_ADDR_STATUS: rdata_out <= status;
                    `UTRX_ADDR_CTRL1:  rdata_out <= {1'b0, rx_head[8] && (fifo_cnt_r != 2'h0), ctrl1_r};
                    `UTRX_ADDR_CTRL2:  rdata_out <= {3'h0, ctrl2_r};
                    `UTRX_ADDR_BAUD:   rdata_out <= baud_div_r;
                    `UTRX_ADDR_DATA:   rdata_out <= (fifo_cnt_r != 2'h0) ? rx_head[7:0] : 8'h00;
                    default:           rdata_out <= 8'h00;
                endcase
            end
            irq_out <= (tx_empty_irq_enable && tx_empty_r && transmitter_enable && tx_st_r != T_BREAK)
                       || (rx_irq_enable && (rx_ev_r || overrun_flag_r));
        end
    end
endmodule

// file: sim/utrx_core_props.sv
// Port-level assertions for the serial transceiver core.
`include "utrx_defs.vh"
module utrx_core_props
(
    input wire       clk_in,     // clock
    input wire       reset_in,   // synchronous reset
    input wire [2:0] addr_in,    // register address
    input wire [7:0] wdata_in,   // write data
    input wire       wr_in,      // write strobe
    input wire       rd_in,      // read strobe
    input wire [7:0] rdata_out,  // read data
    input wire       rx_pin_in,  // receive line
    input wire       tx_pin_out, // transmit line
    input wire       irq_out     // interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shadow of the last control register 2 write, so that enables can be judged from the ports alone.
    reg [7:0] ctrl2_r;
    always @(posedge clk_in)
    begin
        if (reset_in)
            ctrl2_r <= 8'h00;
        else if (wr_in && addr_in == `UTRX_ADDR_CTRL2)
            ctrl2_r <= wdata_in;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    a_irq_masked: assert property (
        (ctrl2_r & 8'h18) == 8'h00 && ($past(ctrl2_r) & 8'h18) == 8'h00 |-> !irq_out)
        else $error("interrupt raised with both enables off");
    a_tx_off_high: assert property (
        !ctrl2_r[0] && !$past(ctrl2_r[0]) |-> tx_pin_out)
        else $error("transmit line low while transmitter disabled");
    a_tx_off_flags: assert property (
        rd_in && addr_in == `UTRX_ADDR_STATUS && !ctrl2_r[0] && !$past(ctrl2_r[0]) |=> rdata_out[7:6] == 2'b11)
        else $error("transmit flags not set while transmitter disabled");
    a_rx_off_flags: assert property (
        rd_in && addr_in == `UTRX_ADDR_STATUS && !ctrl2_r[1] && !$past(ctrl2_r[1]) |=> rdata_out[5:0] == 6'h10)
        else $error("receive status wrong while receiver disabled");
    a_read_once: assert property (
        !rd_in |=> rdata_out == 8'h00)
        else $error("read data present without a read");
    a_ctrl2_back: assert property (
        rd_in && addr_in == `UTRX_ADDR_CTRL2 |=> rdata_out == {3'b000, $past(ctrl2_r[4:0])})
        else $error("control readback differs from last write");
    a_start_min: assert property (
        $fell(tx_pin_out) |-> !tx_pin_out [*8])
        else $error("low bit on transmit line too short");
    a_mark_min: assert property (
        $rose(tx_pin_out) |-> tx_pin_out [*8])
        else $error("high bit on transmit line too short");
endmodule
bind utrx_core utrx_core_props u_props
(
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rx_pin_in(rx_pin_in),
    .tx_pin_out(tx_pin_out), .irq_out(irq_out)
);

// file: sim/utrx_remote.sv
// Behavioural remote transceiver on the two serial lines.
module utrx_remote
#(
    parameter int CPB = 16 // clocks per bit
)
(
    input  wire logic       clk_in,   // bench clock
    input  wire logic       line_in,  // line driven by the core
    input  wire logic [3:0] nbits_in, // bits per frame after the start bit
    output logic            line_out  // line towards the core
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] rx_q [$];
    initial line_out = 1'b1;
    task automatic send(input logic [8:0] w, input logic [3:0] n);
        int i;
        @(posedge clk_in);
        line_out <= 1'b0;
        repeat (CPB) @(posedge clk_in);
        for (i = 0; i < n; i++)
        begin
            line_out <= w[i];
            repeat (CPB) @(posedge clk_in);
        end
        line_out <= 1'b1;
        repeat (CPB) @(posedge clk_in);
    endtask
    // A held low line longer than any frame; the core must not take its tail as a start bit.
    task automatic brk(input int bits);
        @(posedge clk_in);
        line_out <= 1'b0;
        repeat (bits * CPB) @(posedge clk_in);
        line_out <= 1'b1;
    endtask
    initial
    begin : decode
        logic [8:0] w;
        int         i;
        forever
        begin
            wait (line_in === 1'b1);
            wait (line_in === 1'b0);
            repeat (CPB / 2) @(posedge clk_in);
            w = 9'h000;
            for (i = 0; i < nbits_in; i++)
            begin
                repeat (CPB) @(posedge clk_in);
                w[i] = line_in;
            end
            rx_q.push_back(w);
        end
    end
endmodule

// file: sim/uart_tx_rx_datapath_test.sv
// Self-checking bench for the serial transceiver core against a remote peer.
`include "utrx_defs.vh"
module uart_tx_rx_datapath_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] c1; logic [7:0] d; logic [8:0] w; logic [3:0] n; logic [7:0] m;} utrx_row_t;
    logic       clk_in   = 1'b0;
    logic       reset_in = 1'b1;
    logic [2:0] addr_r   = 3'h0;
    logic [7:0] wdata_r  = 8'h00;
    logic       wr_r     = 1'b0;
    logic       rd_r     = 1'b0;
    logic [3:0] nbits_r  = 4'h8;
    logic [7:0] rdata_out;
    logic       rx_pin;
    logic       tx_pin;
    logic       irq_out;
    logic [7:0] st;
    logic [7:0] cr;
    logic [7:0] v;
    int         mismatches = 0;
    int         checked    = 0;
    int         low_run    = 0;
    int         last_low   = 0;
    // Parity formats compare only the seven data bits, since the top bit carries parity.
    utrx_row_t  rows [5] = '{'{8'h00, 8'hA5, 9'h0A5, 4'h8, 8'hFF}, '{8'h21, 8'h3C, 9'h13C, 4'h9, 8'hFF},
                           '{8'h01, 8'hFF, 9'h0FF, 4'h9, 8'hFF}, '{8'h02, 8'h13, 9'h093, 4'h8, 8'h7F},
                           '{8'h0E, 8'h13, 9'h013, 4'h8, 8'h7F}};
    utrx_core DUT
    (
        .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_r), .wdata_in(wdata_r), .wr_in(wr_r),
        .rd_in(rd_r), .rdata_out(rdata_out), .rx_pin_in(rx_pin), .tx_pin_out(tx_pin), .irq_out(irq_out)
    );
    utrx_remote #(.CPB(16)) peer
    (
        .clk_in(clk_in), .line_in(tx_pin), .nbits_in(nbits_r), .line_out(rx_pin)
    );
    initial
    begin
        forever #4 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        low_run <= tx_pin ? 0 : low_run + 1;
        if (tx_pin && low_run != 0)
            last_low <= low_run;
    end
    task automatic finish_test();
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic ok(input logic c);
        checked++;
        if (c !== 1'b1)
        begin
            mismatches++;
            $display("mismatch at %0t: unexpected value", $time);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_r  <= a;
        wdata_r <= d;
        wr_r    <= 1'b1;
        @(posedge clk_in);
        wr_r    <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_r <= a;
        rd_r   <= 1'b1;
        @(posedge clk_in);
        rd_r   <= 1'b0;
        @(posedge clk_in);
        d = rdata_out;
    endtask
    // Polls until a word is available, then reads control and data in the clearing order.
    task automatic rx_get(output logic [7:0] s, output logic [7:0] c, output logic [7:0] d);
        int k;
        s = 8'h00;
        for (k = 0; k < 300 && s[5] !== 1'b1; k++)
            rd(`UTRX_ADDR_STATUS, s);
        rd(`UTRX_ADDR_CTRL1, c);
        rd(`UTRX_ADDR_DATA, d);
    endtask
    task automatic wait_q(input int n);
        int k;
        for (k = 0; k < 2000 && peer.rx_q.size() < n; k++)
            @(posedge clk_in);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        finish_test();
    end
    initial
    begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        for (int a = 0; a < 8; a++)
        begin
            rd(a[2:0], v);
            ok(v === ((a == 0) ? 8'hD0 : 8'h00));
        end
        wr(`UTRX_ADDR_BAUD, 8'h00);
        wr(`UTRX_ADDR_CTRL2, 8'h05);
        peer.send(9'h055, 4'h8);
        wr(`UTRX_ADDR_CTRL2, 8'h07);
        rd(`UTRX_ADDR_STATUS, st);
        ok(st[5:4] === 2'b01);
        foreach (rows[i])
        begin
            nbits_r <= rows[i].n;
            wr(`UTRX_ADDR_CTRL1, rows[i].c1);
            rd(`UTRX_ADDR_STATUS, st);
            wr(`UTRX_ADDR_DATA, rows[i].d);
            wait_q(1);
            ok(peer.rx_q.pop_front() === rows[i].w);
            peer.send(rows[i].w, rows[i].n);
            rx_get(st, cr, v);
            ok(st[5:0] === 6'h30);
            ok((v & rows[i].m) === (rows[i].d & rows[i].m));
            ok(cr[6] === (rows[i].w[8] & rows[i].c1[0]));
        end
        peer.send(9'h093, 4'h8);
        rx_get(st, cr, v);
        ok(st[0] === 1'b1);
        wr(`UTRX_ADDR_CTRL1, 8'h00);
        rd(`UTRX_ADDR_STATUS, st);
        wr(`UTRX_ADDR_DATA, 8'h11);
        rd(`UTRX_ADDR_STATUS, st);
        ok(st[7:6] === 2'b10);
        wr(`UTRX_ADDR_DATA, 8'h22);
        rd(`UTRX_ADDR_STATUS, st);
        ok(st[7] === 1'b0);
        wr(`UTRX_ADDR_DATA, 8'h33);
        wait_q(2);
        ok(peer.rx_q[0] === 9'h011 && peer.rx_q[1] === 9'h022);
        repeat (400) @(posedge clk_in);
        ok(peer.rx_q.size() == 2);
        rd(`UTRX_ADDR_STATUS, st);
        ok(st[7:6] === 2'b11);
        wr(`UTRX_ADDR_CTRL2, 8'h0F);
        repeat (3) @(posedge clk_in);
        ok(irq_out === 1'b1);
        wr(`UTRX_ADDR_CTRL1, 8'h10);
        repeat (100) @(posedge clk_in);
        ok(tx_pin === 1'b0 && irq_out === 1'b0);
        repeat (300) @(posedge clk_in);
        wr(`UTRX_ADDR_CTRL1, 8'h00);
        repeat (500) @(posedge clk_in);
        ok(tx_pin === 1'b1 && last_low > 400 && ((last_low + 8) / 16) % 13 == 1);
        rd(`UTRX_ADDR_STATUS, st);
        ok(st[6] === 1'b1);
        peer.rx_q.delete();
        wr(`UTRX_ADDR_CTRL2, 8'h17);
        peer.send(9'h041, 4'h8);
        peer.send(9'h042, 4'h8);
        peer.send(9'h043, 4'h8);
        repeat (40) @(posedge clk_in);
        ok(irq_out === 1'b1);
        rx_get(st, cr, v);
        ok(st[3] === 1'b1 && v === 8'h41);
        rd(`UTRX_ADDR_DATA, v);
        ok(v === 8'h42);
        rd(`UTRX_ADDR_STATUS, st);
        ok(st[5] === 1'b0 && st[3] === 1'b0);
        wr(`UTRX_ADDR_CTRL2, 8'h07);
        fork
            peer.brk(30);
        join_none
        repeat (100) @(posedge clk_in);
        rd(`UTRX_ADDR_STATUS, st);
        ok(st[4] === 1'b0);
        wait fork;
        rx_get(st, cr, v);
        ok(st[2] === 1'b1 && st[4] === 1'b1 && v === 8'h00);
        repeat (200) @(posedge clk_in);
        rd(`UTRX_ADDR_STATUS, st);
        ok(st[5] === 1'b0);
        peer.send(9'h05A, 4'h8);
        rx_get(st, cr, v);
        ok(v === 8'h5A && st[2] === 1'b0);
        // Low-speed baud select: four clocks per tick, so the start bit spans 61 to 64 clocks.
        wr(`UTRX_ADDR_CTRL2, 8'h03);
        wr(`UTRX_ADDR_DATA, 8'h01);
        repeat (100) @(posedge clk_in);
        ok(last_low >= 61 && last_low <= 64);
        finish_test();
    end
endmodule
